// ===== common/srm_pkg.sv
// Constants, types and register layout for the receive channel 7/8 slot mapper
// Behaviour
// - Channel 7 field picks off/playback/loopback/linked source
// - Channel 8 field picks off/playback/loopback/linked source
// - Channel 7 slot field resets to slot six
// - Channel 8 slot field resets to slot seven
// - TDM slot value equals frame slot number
// - Top bit reserved, reads zero, write zero
package srm_pkg;

	// ==========================================
	// Register map
	localparam int SRM_CHANNELS = 2;
	localparam logic [SRM_CHANNELS-1:0][7:0] SRM_CH_ADDR = {8'h2f, 8'h2e};
	localparam logic [SRM_CHANNELS-1:0][7:0] SRM_CH_RST = {8'h07, 8'h06};
	localparam int SRM_RSV_BIT = 7;
	localparam int SRM_SRC_HI = 6;
	localparam int SRM_SRC_LO = 5;
	localparam int SRM_SLOT_HI = 4;
	localparam int SRM_SLOT_LO = 0;
	localparam int SRM_ROUTE_W = 7;
	localparam logic [7:0] SRM_RD_UNMAPPED = 8'h00;

	// ==========================================
	// Framing
	localparam logic [1:0] SRM_FMT_TDM = 2'h0;
	localparam logic [1:0] SRM_FMT_I2S = 2'h1;
	localparam logic [1:0] SRM_FMT_LJ = 2'h2;
	localparam int SRM_DATA_W = 32;
	localparam int SRM_SLOT_W = 5;
	localparam int SRM_BITCNT_W = 6;
	localparam logic [SRM_SLOT_W:0] SRM_TDM_SLOTS = 6'h20;
	localparam logic [SRM_SLOT_W:0] SRM_HALF_SLOTS = 6'h10;
	localparam logic [SRM_BITCNT_W-1:0] SRM_BIT_ONE = 6'h01;
	localparam logic [SRM_SLOT_W:0] SRM_SLOT_ONE = 6'h01;

	// ==========================================
	// Types
	typedef enum logic [1:0] {SRM_SRC_OFF, SRM_SRC_PLAYBACK, SRM_SRC_LOOPBACK, SRM_SRC_LINKED} srm_src_t;

	typedef struct packed {
		srm_src_t src;
		logic [SRM_SLOT_W-1:0] slot;
	} srm_route_t;

	typedef struct packed {
		logic stb;
		logic bit_val;
		logic [SRM_SLOT_W-1:0] code;
		logic last;
	} srm_bit_t;

	typedef struct packed {
		srm_src_t src;
		logic [SRM_DATA_W-1:0] data;
	} srm_word_t;

endpackage

// ===== hdl/srm_slot_capture.sv
// One receive channel: collects the bits of its selected slot into a word
`timescale 1ns/1ps
module srm_slot_capture
	import srm_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Bit stream and routing
	input srm_bit_t bit_in,
	input srm_route_t route,
	// Captured word
	output srm_word_t word_out,
	output logic word_valid
);

	// ==========================================
	// Capture
	logic [SRM_DATA_W-1:0] shift;
	logic [SRM_DATA_W-1:0] next_shift;
	srm_word_t next_word;
	logic next_valid;
	logic hit;

	always_comb
	begin
		hit = bit_in.stb && (route.src != SRM_SRC_OFF) && (bit_in.code == route.slot);
		next_shift = shift;
		next_word = word_out;
		next_valid = 1'b0;
		if (hit)
		begin
			next_shift = {shift[SRM_DATA_W-2:0], bit_in.bit_val};
			if (bit_in.last)
			begin
				// Source tag tells the consumer which path receives the word
				next_word.src = route.src;
				next_word.data = {shift[SRM_DATA_W-2:0], bit_in.bit_val};
				next_valid = 1'b1;
				next_shift = '0;
			end
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			shift <= '0;
			word_out <= '0;
			word_valid <= 1'b0;
		end
		else
		begin
			shift <= next_shift;
			word_out <= next_word;
			word_valid <= next_valid;
		end
	end

endmodule

// ===== hdl/srm_slot_mapper.sv
// Primary serial audio port receive slot mapper for channels 7 and 8
`timescale 1ns/1ps
module srm_slot_mapper
	import srm_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Register port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	// Frame settings held elsewhere
	input wire logic [1:0] frame_fmt,
	input wire logic [SRM_BITCNT_W-1:0] word_bits,
	// Serial audio port pins
	input wire logic sap_bclk,
	input wire logic sap_fsync,
	input wire logic sap_din,
	// Receive channel outputs, index 0 is channel 7
	output srm_word_t [SRM_CHANNELS-1:0] rx_word,
	output logic [SRM_CHANNELS-1:0] rx_valid
);

	// ==========================================
	// Registers
	srm_route_t [SRM_CHANNELS-1:0] route;
	srm_route_t [SRM_CHANNELS-1:0] next_route;
	logic [7:0] next_rdata;
	logic next_rvalid;

	always_comb
	begin
		next_route = route;
		next_rdata = reg_rdata;
		next_rvalid = reg_rd;
		if (reg_rd)
			next_rdata = SRM_RD_UNMAPPED;
		for (int i = 0; i < SRM_CHANNELS; i++)
		begin
			if (reg_wr && reg_addr == SRM_CH_ADDR[i])
				next_route[i] = srm_route_t'(reg_wdata[SRM_SRC_HI:SRM_SLOT_LO]);
			if (reg_rd && reg_addr == SRM_CH_ADDR[i])
				next_rdata = {1'b0, route[i]};
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			for (int i = 0; i < SRM_CHANNELS; i++)
				route[i] <= srm_route_t'(SRM_CH_RST[i][SRM_ROUTE_W-1:0]);
			reg_rdata <= 8'h00;
			reg_rvalid <= 1'b0;
		end
		else
		begin
			route <= next_route;
			reg_rdata <= next_rdata;
			reg_rvalid <= next_rvalid;
		end
	end

	// ==========================================
	// Pin synchronisers
	// Bit order in each stage: bclk, fsync, din
	logic [2:0] sync1;
	logic [2:0] sync2;
	logic [2:0] sync3;
	logic bclk_rise;
	logic fs_now;
	logic din_now;

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			sync1 <= 3'h0;
			sync2 <= 3'h0;
			sync3 <= 3'h0;
		end
		else
		begin
			sync1 <= {sap_bclk, sap_fsync, sap_din};
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	// Data and frame sync are taken on the same delayed edge, so their skew to bclk is kept
	assign bclk_rise = sync2[2] & ~sync3[2];
	assign fs_now = sync2[1];
	assign din_now = sync2[0];

	// ==========================================
	// Frame and slot tracking
	typedef enum logic {SRM_HUNT, SRM_RUN} srm_state_t;

	srm_state_t state;
	srm_state_t next_state;
	logic fs_last;
	logic fs_last2;
	logic next_fs_last;
	logic next_fs_last2;
	logic right_half;
	logic next_right_half;
	logic [SRM_SLOT_W:0] slot_cnt;
	logic [SRM_SLOT_W:0] next_slot_cnt;
	logic [SRM_BITCNT_W-1:0] bit_cnt;
	logic [SRM_BITCNT_W-1:0] next_bit_cnt;
	srm_bit_t bit_out;
	srm_bit_t next_bit_out;
	logic start;
	logic start_right;
	logic [SRM_SLOT_W:0] slot_limit;

	always_comb
	begin
		next_state = state;
		next_fs_last = fs_last;
		next_fs_last2 = fs_last2;
		next_right_half = right_half;
		next_slot_cnt = slot_cnt;
		next_bit_cnt = bit_cnt;
		next_bit_out = bit_out;
		next_bit_out.stb = 1'b0;
		start = 1'b0;
		start_right = 1'b0;
		slot_limit = SRM_HALF_SLOTS;
		case (frame_fmt)
			SRM_FMT_TDM:
			begin
				start = fs_now & ~fs_last;
				slot_limit = SRM_TDM_SLOTS;
			end
			SRM_FMT_I2S:
			begin
				// Half begins one bit after the sync edge; high sync marks the right half
				start = fs_last ^ fs_last2;
				start_right = fs_last;
			end
			SRM_FMT_LJ:
			begin
				start = fs_now ^ fs_last;
				start_right = ~fs_now;
			end
			default:
			begin
				// No framing selected: drop back to hunting so stale slot counts never strobe bits
				start = 1'b0;
				next_state = SRM_HUNT;
			end
		endcase
		if (bclk_rise)
		begin
			next_fs_last = fs_now;
			next_fs_last2 = fs_last;
			if (start)
			begin
				next_state = SRM_RUN;
				next_slot_cnt = '0;
				next_bit_cnt = '0;
				next_right_half = start_right;
			end
			else if (bit_cnt == word_bits - SRM_BIT_ONE)
			begin
				next_bit_cnt = '0;
				// Stop counting past the last slot so bits beyond it never alias slot 0
				if (slot_cnt < slot_limit)
					next_slot_cnt = slot_cnt + SRM_SLOT_ONE;
			end
			else
				next_bit_cnt = bit_cnt + SRM_BIT_ONE;
			next_bit_out.stb = (next_state == SRM_RUN) && (next_slot_cnt < slot_limit);
			next_bit_out.bit_val = din_now;
			next_bit_out.last = (next_bit_cnt == word_bits - SRM_BIT_ONE);
			if (frame_fmt == SRM_FMT_TDM)
				next_bit_out.code = next_slot_cnt[SRM_SLOT_W-1:0];
			else
				next_bit_out.code = {next_right_half, next_slot_cnt[SRM_SLOT_W-2:0]};
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			state <= SRM_HUNT;
			fs_last <= 1'b0;
			fs_last2 <= 1'b0;
			right_half <= 1'b0;
			slot_cnt <= '0;
			bit_cnt <= '0;
			bit_out <= '0;
		end
		else
		begin
			state <= next_state;
			fs_last <= next_fs_last;
			fs_last2 <= next_fs_last2;
			right_half <= next_right_half;
			slot_cnt <= next_slot_cnt;
			bit_cnt <= next_bit_cnt;
			bit_out <= next_bit_out;
		end
	end

	// ==========================================
	// Channel capture units
	genvar ch;
	generate
		for (ch = 0; ch < SRM_CHANNELS; ch++)
		begin : g_ch
			srm_slot_capture i_srm_slot_capture (
				.core_clk(core_clk),
				.rst(rst),
				.bit_in(bit_out),
				.route(route[ch]),
				.word_out(rx_word[ch]),
				.word_valid(rx_valid[ch])
			);
		end
	endgenerate

endmodule

// ===== tb/srm_properties.sv
// Port checker for the channel 7/8 slot mapper
`timescale 1ns/1ps
module srm_properties
	import srm_pkg::*;
(
	// Clock, reset and register port
	input wire logic core_clk,
	input wire logic rst,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid,
	// Receive channels
	input wire logic [SRM_CHANNELS-1:0] rx_valid,
	input srm_word_t [SRM_CHANNELS-1:0] rx_word
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// ==========================================
	// Shadow routes, so reads and sources can be predicted
	logic [6:0] r7, r8, next_r7, next_r8;
	always_comb
	begin
		next_r7 = r7;
		next_r8 = r8;
		if (reg_wr && reg_addr == 8'h2e)
			next_r7 = reg_wdata[6:0];
		if (reg_wr && reg_addr == 8'h2f)
			next_r8 = reg_wdata[6:0];
		if (rst)
		begin
			next_r7 = 7'h06;
			next_r8 = 7'h07;
		end
	end
	always_ff @(posedge core_clk)
	begin
		r7 <= next_r7;
		r8 <= next_r8;
	end
	// ==========================================
	// Properties
	AST_RD_ANSWER: assert property (reg_rd |=> reg_rvalid)
		else $error("read not answered");
	AST_RD_QUIET: assert property (!reg_rd |=> !reg_rvalid)
		else $error("spurious read valid");
	AST_RSV_ZERO: assert property (reg_rvalid |-> !reg_rdata[7])
		else $error("reserved bit set");
	AST_RD7: assert property (reg_rd && reg_addr == 8'h2e |=> reg_rdata == {1'b0, r7})
		else $error("channel 7 read wrong");
	AST_RD8: assert property (reg_rd && reg_addr == 8'h2f |=> reg_rdata == {1'b0, r8})
		else $error("channel 8 read wrong");
	AST_SRC7: assert property (rx_valid[0] |-> rx_word[0].src == r7[6:5])
		else $error("channel 7 source wrong");
	AST_SRC8: assert property (rx_valid[1] |-> rx_word[1].src == r8[6:5])
		else $error("channel 8 source wrong");
	AST_OFF: assert property ((rx_valid & {|r8[6:5], |r7[6:5]}) == rx_valid)
		else $error("disabled channel produced a word");
	cover property (rx_valid[0]);
	cover property (rx_valid[1]);
	cover property (reg_rvalid && reg_rdata == 8'h06);
endmodule

// ===== tb/srm_host.sv
// Host model that sends audio frames on the serial port
`timescale 1ns/1ps
module srm_host
	import srm_pkg::*;
(
	// Serial port pins
	output logic sap_bclk,
	output logic sap_fsync,
	output logic sap_din
);
	initial
	begin
		sap_bclk = 1'b0;
		sap_fsync = 1'b0;
		sap_din = 1'b0;
	end
	// Each slot value carries its own word, so a wrong slot shows
	function automatic logic [31:0] word_of(input int v);
		return 32'hc35a_9600 + 32'(v);
	endfunction
	// Two lead bits give I2S and LJ a fresh edge; bclk idles low between frames
	task automatic frame(input logic [1:0] fmt, input int wb);
		logic [31:0] w;
		for (int i = -2; i < 32 * wb; i++)
		begin
			if (fmt == SRM_FMT_TDM)
				sap_fsync = (i == 0);
			else if (fmt == SRM_FMT_I2S)
				sap_fsync = (i < -1) || (i + 1 >= 16 * wb);
			else
				sap_fsync = (i >= 0) && (i < 16 * wb);
			w = word_of((i < 0) ? 0 : i / wb);
			sap_din = (i < 0) ? 1'b0 : w[wb - 1 - i % wb];
			#100 sap_bclk = 1'b1;
			#100 sap_bclk = 1'b0;
		end
		// Released line shows the inverse, never a stale bit
		sap_din = ~sap_din;
	endtask
endmodule

// ===== tb/srm_slot_mapper_bench.sv
// Self-checking bench for the channel 7/8 slot mapper
`timescale 1ns/1ps
module srm_slot_mapper_bench;
	import srm_pkg::*;
	logic core_clk, rst, reg_wr, reg_rd, reg_rvalid, sap_bclk, sap_fsync, sap_din;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic [1:0] frame_fmt;
	logic [SRM_BITCNT_W-1:0] word_bits;
	srm_word_t [SRM_CHANNELS-1:0] rx_word, got;
	logic [SRM_CHANNELS-1:0] rx_valid;
	int num_errors, n_tests, cycles;
	int cnt [2];
	srm_slot_mapper i_srm_slot_mapper (.core_clk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
		.reg_rvalid, .frame_fmt, .word_bits, .sap_bclk, .sap_fsync, .sap_din, .rx_word, .rx_valid);
	srm_host i_srm_host (.sap_bclk, .sap_fsync, .sap_din);
	initial
	begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	// ==========================================
	// Word monitor and hang guard
	always @(negedge core_clk)
	begin
		cycles++;
		for (int c = 0; c < 2; c++)
			if (rx_valid[c] === 1'b1)
			begin
				got[c] = rx_word[c];
				cnt[c]++;
			end
		if (cycles == 60000)
		begin
			num_errors++;
			wrap_up();
		end
	end
	task automatic chk(input string what, input logic [33:0] exp, input logic [33:0] seen);
		n_tests++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge core_clk);
		reg_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge core_clk);
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge core_clk);
		reg_rd = 1'b0;
		// The valid pulse stands for one cycle only, so judge it here
		chk("read valid", 34'h1, 34'(reg_rvalid));
		chk("read data", 34'(exp), 34'(reg_rdata));
	endtask
	// Routes both channels, sends one frame, then judges the words
	task automatic run(input logic [1:0] fmt, input int wb, input logic [1:0] s7, s8, input int v7, v8);
		logic [32:0] m;
		m = (33'h1 << wb) - 33'h1;
		wr(8'h2e, {1'b0, s7, 5'(v7)});
		wr(8'h2f, {1'b0, s8, 5'(v8)});
		frame_fmt = fmt;
		word_bits = 6'(wb);
		cnt = '{0, 0};
		i_srm_host.frame(fmt, wb);
		repeat (20) @(negedge core_clk);
		chk("ch7 count", 34'(s7 != 2'h0), 34'(cnt[0]));
		chk("ch8 count", 34'(s8 != 2'h0), 34'(cnt[1]));
		if (s7 != 2'h0)
			chk("ch7 word", {s7, i_srm_host.word_of(v7) & m[31:0]}, got[0]);
		if (s8 != 2'h0)
			chk("ch8 word", {s8, i_srm_host.word_of(v8) & m[31:0]}, got[1]);
	endtask
	// ==========================================
	// Scenarios
	task automatic t_regs();
		rd(8'h2e, 8'h06);
		rd(8'h2f, 8'h07);
		rd(8'h30, 8'h00);
		wr(8'h2e, 8'hff);
		rd(8'h2e, 8'h7f);
		wr(8'h31, 8'h55);
		rd(8'h2f, 8'h07);
		$display("registers done");
	endtask
	task automatic t_sources();
		for (int s = 0; s < 4; s++)
			run(SRM_FMT_TDM, 16, 2'(s), 2'(3 - s), 0, 31);
		$display("sources done");
	endtask
	task automatic t_halves();
		run(SRM_FMT_I2S, 24, 2'h1, 2'h2, 15, 16);
		run(SRM_FMT_LJ, 32, 2'h3, 2'h1, 16, 15);
		$display("halves done");
	endtask
	// No framing selected: routes aim at the codes left over from the last frame, yet no word may appear
	task automatic t_no_format();
		wr(8'h2e, 8'h3f);
		wr(8'h2f, 8'h4f);
		frame_fmt = 2'h3;
		word_bits = 6'h10;
		cnt = '{0, 0};
		i_srm_host.frame(2'h3, 16);
		repeat (20) @(negedge core_clk);
		chk("idle ch7 count", 34'h0, 34'(cnt[0]));
		chk("idle ch8 count", 34'h0, 34'(cnt[1]));
		$display("no format done");
	endtask
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial
	begin
		rst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		frame_fmt = SRM_FMT_TDM;
		word_bits = 6'h10;
		repeat (6) @(negedge core_clk);
		rst = 1'b0;
		t_regs();
		t_sources();
		t_halves();
		t_no_format();
		wrap_up();
	end
endmodule
bind srm_slot_mapper srm_properties i_srm_properties (.core_clk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
	.reg_rdata, .reg_rvalid, .rx_valid, .rx_word);
